// file: design/flash_controller.v
`default_nettype none
module flash_controller #(
  parameter [2:0]  PAGE_SIZE_CODE = 3'h3,
  parameter [15:0] PAGE_COUNT     = 16'h0400,
  parameter [21:0] USER_ROW_ADDR  = 22'h002000,
  parameter        ROW_SHIFT      = 6,
  parameter [21:0] LOCK_ROW_ADDR  = 22'h003000
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  input  wire [7:0]  reg_addr,
  input  wire        reg_write,
  input  wire [31:0] reg_wdata,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  output reg         op_start,
  output reg  [6:0]  op_cmd,
  output reg  [21:0] op_addr,
  output reg  [7:0]  op_data,
  input  wire        op_done,
  input  wire        op_error,
  input  wire        security_active,
  input  wire        buf_store,
  input  wire        buf_last,
  input  wire [21:0] buf_addr,
  output reg         buf_clear,
  output reg         cache_invalidate,
  output reg         cache_enable,
  output reg         power_reduced,
  input  wire        sleep_enter,
  input  wire        sleep_exit,
  input  wire        flash_access,
  input  wire        rd_req,
  input  wire        rd_hit,
  output wire        rd_ack,
  output wire        rd_busy
);
`include "flash_map.vh"
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  reg  [1:0]  state_reg;
  reg  [31:0] control_second_reg;
  reg  [21:0] address_reg;
  reg         programming_error_reg;
  reg         memory_error_reg;
  reg         load_reg;
  reg         security_reg;

  wire [1:0]  read_policy        = control_second_reg[17:16];
  wire [1:0]  sleep_power_policy = control_second_reg[9:8];
  wire        manual_write       = control_second_reg[`BIT_MANUAL_WRITE];
  wire [3:0]  read_wait_states   = control_second_reg[4:1];
  wire        ready              = state_reg[0];

  wire        wr_cmd   = reg_write && reg_addr == `OFS_CONTROL_A;
  wire        wr_stat  = reg_write && reg_addr == `OFS_STATUS;
  wire [7:0]  execution_key = reg_wdata[15:8];
  wire [6:0]  cmd_code      = reg_wdata[6:0];
  wire        key_ok   = execution_key == `EXECUTION_KEY;

  reg         cmd_known;
  reg         cmd_array;
  reg         cmd_allowed;
  always @* begin
    cmd_known   = 1'b1;
    cmd_array   = 1'b1;
    cmd_allowed = 1'b1;
    case (cmd_code)
      `CMD_ERASE_ROW, `CMD_WRITE_PAGE, `CMD_LOCK_REGION,
      `CMD_UNLOCK_REGION, `CMD_SET_SECURITY: cmd_array = 1'b1;
      `CMD_ERASE_AUX_ROW, `CMD_WRITE_AUX_PAGE: begin
        cmd_allowed = !security_reg &&
          (address_reg >> ROW_SHIFT) == (USER_ROW_ADDR >> ROW_SHIFT);
      end
      `CMD_SET_POWER_RED, `CMD_CLEAR_POWER_RED,
      `CMD_PAGE_BUF_CLEAR, `CMD_INVALIDATE_CACHE: cmd_array = 1'b0;
      default: begin
        cmd_known = 1'b0;
        cmd_array = 1'b0;
      end
    endcase
  end

  wire cmd_issue  = wr_cmd && key_ok && cmd_known && cmd_allowed && ready;
  wire cmd_reject = wr_cmd && !(key_ok && cmd_known && cmd_allowed && ready);
  wire auto_write = !manual_write && buf_store && buf_last && ready;
  wire local_cmd  = cmd_issue && !cmd_array;

  // Command sequencer
  always @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      op_start  <= 1'b0;
      op_cmd    <= 7'h00;
      op_addr   <= 22'h000000;
      op_data   <= 8'hff;
    end else if (ce) begin
      op_start <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (cmd_issue && cmd_array) begin
            state_reg <= ST_BUSY;
            op_start  <= 1'b1;
            op_cmd    <= cmd_code;
            op_addr   <= (cmd_code == `CMD_SET_SECURITY) ? LOCK_ROW_ADDR : address_reg;
            op_data   <= `SECURITY_BYTE_VALUE;
          end else if (auto_write) begin
            state_reg <= ST_BUSY;
            op_start  <= 1'b1;
            op_cmd    <= `CMD_WRITE_PAGE;
            op_addr   <= buf_addr;
          end
        end
        ST_BUSY: begin
          if (op_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Local commands and power reduction
  always @(posedge clk) begin
    if (reset) begin
      buf_clear        <= 1'b0;
      cache_invalidate <= 1'b0;
      power_reduced    <= 1'b0;
      cache_enable     <= 1'b1;
    end else if (ce) begin
      buf_clear        <= local_cmd && cmd_code == `CMD_PAGE_BUF_CLEAR;
      cache_invalidate <= local_cmd && cmd_code == `CMD_INVALIDATE_CACHE;
      cache_enable     <= !control_second_reg[`BIT_CACHE_OFF];
      if (local_cmd && cmd_code == `CMD_SET_POWER_RED) begin
        power_reduced <= 1'b1;
      end else if (local_cmd && cmd_code == `CMD_CLEAR_POWER_RED) begin
        power_reduced <= 1'b0;
      end else if (sleep_enter && (sleep_power_policy == `SLEEP_WAKE_ON_ACCESS ||
                                   sleep_power_policy == `SLEEP_WAKE_ON_EXIT)) begin
        power_reduced <= 1'b1;
      end else if (sleep_exit && sleep_power_policy == `SLEEP_WAKE_ON_EXIT) begin
        power_reduced <= 1'b0;
      end else if (flash_access) begin
        power_reduced <= 1'b0;
      end
    end
  end

  // Registers
  always @(posedge clk) begin
    if (reset) begin
      control_second_reg    <= `CTRL_SECOND_RESET;
      address_reg           <= 22'h000000;
      programming_error_reg <= 1'b0;
      memory_error_reg      <= 1'b0;
      load_reg              <= 1'b0;
      security_reg          <= 1'b0;
    end else if (ce) begin
      security_reg <= security_active;
      if (reg_write && reg_addr == `OFS_CONTROL_SECOND) begin
        control_second_reg <= reg_wdata & `CTRL_SECOND_MASK;
      end
      if (reg_write && reg_addr == `OFS_ADDRESS) begin
        address_reg <= reg_wdata[21:0];
      end
      if (cmd_reject) begin
        programming_error_reg <= 1'b1;
      end else if (wr_stat && reg_wdata[2]) begin
        programming_error_reg <= 1'b0;
      end
      if (op_done && op_error) begin
        memory_error_reg <= 1'b1;
      end else if (wr_stat && reg_wdata[4]) begin
        memory_error_reg <= 1'b0;
      end
      if (buf_store) begin
        load_reg <= 1'b1;
      end else if ((cmd_issue && (cmd_code == `CMD_PAGE_BUF_CLEAR || cmd_code == `CMD_WRITE_PAGE ||
                   cmd_code == `CMD_WRITE_AUX_PAGE)) || (wr_stat && reg_wdata[1])) begin
        load_reg <= 1'b0;
      end
    end
  end

  // Read data, parameter register is constant
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (ce && reg_read) begin
      case (reg_addr)
        `OFS_CONTROL_SECOND: reg_rdata <= control_second_reg;
        `OFS_MEMORY_PARAMS:  reg_rdata <= {13'h0000, PAGE_SIZE_CODE, PAGE_COUNT};
        `OFS_READY:          reg_rdata <= {31'h00000000, ready};
        `OFS_STATUS:         reg_rdata <= {23'h000000, security_reg, 3'h0, memory_error_reg,
                                           1'b0, programming_error_reg, load_reg, power_reduced};
        `OFS_ADDRESS:        reg_rdata <= {10'h000, address_reg};
        default:             reg_rdata <= 32'h00000000;
      endcase
    end
  end

  flash_read_timing u_read_timing (
    .clk              (clk),
    .reset            (reset),
    .ce               (ce),
    .rd_req           (rd_req),
    .rd_hit           (rd_hit),
    .read_policy      (read_policy),
    .read_wait_states (read_wait_states),
    .rd_ack           (rd_ack),
    .rd_busy          (rd_busy)
  );
endmodule
`default_nettype wire

// file: common/flash_map.vh
// Behaviour
// - Code 0x06 writes page buffer to aux page; only secure-clear and user row.
// - Code 0x40 locks the region holding the address register location.
// - Code 0x41 unlocks the region holding the address register location.
// - Code 0x42 enters power reduction; status flag reports it.
// - Code 0x43 leaves power reduction.
// - Code 0x44 clears the whole page buffer.
// - Code 0x45 sets security by programming 0x00 into lock row byte zero.
// - Code 0x46 invalidates every read cache line.
// - Bit 18 of control_second disables the cache when one.
// - Read policy bits 17:16 value 0: no extra wait on miss.
// - Read policy value 1: one extra wait state on each miss.
// - Read policy value 2: hit and miss both take programmed waits; 3 reserved.
// - Sleep policy 0: low power on sleep entry, leave on first access.
// - Sleep policy 1: low power on sleep entry, leave on sleep exit.
// - Sleep policy 3: never enter power reduction on sleep.
// - Manual write bit 7 resets to one.
// - Manual write 0: storing last buffer word while ready starts page write to the page at buf_addr unless an array command starts in that cycle.
// - Manual write 1: no automatic write; host issues write command.
// - Read wait field bits 4:1 sets 0 to 15 wait states, applied to hits and misses as the read policy lines state.
// - Read wait field resets to zero; software raises it as needed.
// - Parameter bits 18:16 report page size code, 8 to 1024 bytes.
// - Command runs only with key 0xA5 written together with the code.
// - Invalid code or wrong key sets the programming error bit.
// - Parameter bits 15:0 report the number of main pages.
// - Ready reads 0 while busy, 1 when a command can be taken.
`ifndef FLASH_MAP_VH
`define FLASH_MAP_VH
`define OFS_CONTROL_A        8'h00
`define OFS_CONTROL_SECOND   8'h04
`define OFS_MEMORY_PARAMS    8'h08
`define OFS_READY            8'h14
`define OFS_STATUS           8'h18
`define OFS_ADDRESS          8'h1c
`define CTRL_SECOND_RESET    32'h00000080
`define CTRL_SECOND_MASK     32'h0007039e
`define BIT_CACHE_OFF        18
`define BIT_MANUAL_WRITE     7
`define EXECUTION_KEY        8'ha5
`define CMD_ERASE_ROW        7'h02
`define CMD_WRITE_PAGE       7'h04
`define CMD_ERASE_AUX_ROW    7'h05
`define CMD_WRITE_AUX_PAGE   7'h06
`define CMD_LOCK_REGION      7'h40
`define CMD_UNLOCK_REGION    7'h41
`define CMD_SET_POWER_RED    7'h42
`define CMD_CLEAR_POWER_RED  7'h43
`define CMD_PAGE_BUF_CLEAR   7'h44
`define CMD_SET_SECURITY     7'h45
`define CMD_INVALIDATE_CACHE 7'h46
`define POLICY_FAST_MISS     2'h0
`define POLICY_LOW_POWER     2'h1
`define POLICY_DETERMINISTIC 2'h2
`define SLEEP_WAKE_ON_ACCESS 2'h0
`define SLEEP_WAKE_ON_EXIT   2'h1
`define SLEEP_DISABLED       2'h3
`define SECURITY_BYTE_VALUE  8'h00
`endif

// file: design/flash_read_timing.v
`default_nettype none
module flash_read_timing (
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  input  wire        rd_req,
  input  wire        rd_hit,
  input  wire [1:0]  read_policy,
  input  wire [3:0]  read_wait_states,
  output reg         rd_ack,
  output reg         rd_busy
);
`include "flash_map.vh"
  reg [4:0] wait_reg;
  reg [4:0] waits;

  always @* begin
    case (read_policy)
      `POLICY_FAST_MISS:     waits = rd_hit ? 5'h00 : {1'b0, read_wait_states};
      `POLICY_LOW_POWER:     waits = rd_hit ? 5'h00 : {1'b0, read_wait_states} + 5'h01;
      `POLICY_DETERMINISTIC: waits = {1'b0, read_wait_states};
      default:               waits = {1'b0, read_wait_states};
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      rd_ack   <= 1'b0;
      rd_busy  <= 1'b0;
      wait_reg <= 5'h00;
    end else if (ce) begin
      rd_ack <= 1'b0;
      if (!rd_busy && rd_req) begin
        if (waits == 5'h00) begin
          rd_ack <= 1'b1;
        end else begin
          rd_busy  <= 1'b1;
          wait_reg <= waits;
        end
      end else if (rd_busy) begin
        if (wait_reg == 5'h01) begin
          rd_busy <= 1'b0;
          rd_ack  <= 1'b1;
        end
        wait_reg <= wait_reg - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/flash_array_model.sv
`default_nettype none
module flash_array_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic op_start,
  output var  logic op_done,
  output var  logic op_error
);
  timeunit 1ns;
  timeprecision 1ps;
  int left;
  // Array stays busy a random span, then reports done once
  always @(posedge clk) begin
    op_done  <= 1'b0;
    op_error <= 1'b0;
    if (reset) left <= 0;
    else if (op_start) left <= 2 + $urandom_range(4);
    else if (left == 1) op_done <= 1'b1;
    if (!reset && !op_start && left > 0) left <= left - 1;
  end
endmodule
`default_nettype wire

// file: verification/flash_controller_props.sv
`default_nettype none
module flash_controller_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_write,
  input wire logic [31:0] reg_wdata,
  input wire logic        op_start,
  input wire logic        op_done,
  input wire logic [6:0]  op_cmd,
  input wire logic [7:0]  op_data,
  input wire logic        buf_clear,
  input wire logic        cache_invalidate,
  input wire logic        cache_enable,
  input wire logic        power_reduced,
  input wire logic        rd_req,
  input wire logic        rd_busy,
  input wire logic        rd_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire       cw  = ce && reg_write && reg_addr == 8'h00;
  wire       key = reg_wdata[15:8] == 8'ha5;
  wire [6:0] cc  = reg_wdata[6:0];
  logic      busy_reg;
  always @(posedge clk) begin
    if (reset) busy_reg <= 1'b0;
    else if (ce && op_start) busy_reg <= 1'b1;
    else if (ce && op_done) busy_reg <= 1'b0;
  end
  wire       idle = !busy_reg && !op_start;
  wire       go   = cw && key && idle;
  a_key_needed: assert property (cw && !key |=> !op_start && !buf_clear && !cache_invalidate)
    else $error("command ran without key");
  a_reserved_idle: assert property (cw && ((cc > 7'h06 && cc < 7'h40) || cc > 7'h46) |=> !op_start)
    else $error("reserved code started an operation");
  a_cmd_code: assert property (go && cc inside {7'h40, 7'h41} |=> op_start && op_cmd == $past(cc))
    else $error("region command not passed on");
  a_security_byte: assert property (op_start && op_cmd == 7'h45 |-> op_data == 8'h00)
    else $error("security byte not zero");
  a_power_set: assert property (go && cc == 7'h42 |=> power_reduced)
    else $error("power reduction not entered");
  a_power_clear: assert property (go && cc == 7'h43 |=> !power_reduced)
    else $error("power reduction not left");
  a_buf_clear: assert property (go && cc == 7'h44 |=> buf_clear)
    else $error("page buffer not cleared");
  a_cache_inval: assert property (go && cc == 7'h46 |=> cache_invalidate)
    else $error("cache not invalidated");
  a_busy_refuse: assert property (cw && key && !idle |=> !op_start && !buf_clear && !cache_invalidate)
    else $error("command taken while busy");
  a_cache_off: assert property (ce && reg_write && reg_addr == 8'h04 ##1 ce |=>
    cache_enable == !$past(reg_wdata[18], 2))
    else $error("cache enable wrong");
  a_read_bound: assert property (rd_req && !rd_busy |-> ##[1:17] rd_ack)
    else $error("read not answered in time");
endmodule
bind flash_controller flash_controller_props u_props (.clk(clk), .reset(reset), .ce(ce),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .op_start(op_start),
  .op_cmd(op_cmd), .op_data(op_data), .buf_clear(buf_clear), .cache_invalidate(cache_invalidate),
  .cache_enable(cache_enable), .power_reduced(power_reduced), .rd_req(rd_req), .rd_busy(rd_busy),
  .rd_ack(rd_ack), .op_done(op_done));
`default_nettype wire

// file: verification/nvm_command_and_cache_config_tb.sv
`default_nettype none
`include "flash_map.vh"
module nvm_command_and_cache_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_write = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_read = 1'b0;
  logic        security_active = 1'b0;
  logic        hit = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic [21:0] buf_addr = 22'h0;
  wire  [31:0] reg_rdata;
  wire  [6:0]  op_cmd;
  wire  [21:0] op_addr;
  wire  [7:0]  op_data;
  wire         op_start, op_done, op_error, buf_clear, cache_invalidate;
  wire         cache_enable, power_reduced, rd_ack, rd_busy;
  logic [6:0]  seen_cmd;
  logic [21:0] seen_addr;
  logic [7:0]  seen_data;
  logic [6:0]  codes [4] = '{7'h40, 7'h41, 7'h45, 7'h04};
  logic [1:0]  sp [3] = '{2'h0, 2'h1, 2'h3};
  logic [31:0] d, r;
  int          starts = 0;
  int          clears = 0;
  int          invals = 0;
  int          err_total = 0;
  int          compares = 0;
  int          n, w;
  always #4 clk = ~clk;
  flash_controller u_flash_controller (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .op_start(op_start), .op_cmd(op_cmd), .op_addr(op_addr), .op_data(op_data), .op_done(op_done),
    .op_error(op_error), .security_active(security_active), .buf_store(ev[4]), .buf_last(ev[5]),
    .buf_addr(buf_addr), .buf_clear(buf_clear), .cache_invalidate(cache_invalidate),
    .cache_enable(cache_enable), .power_reduced(power_reduced), .sleep_enter(ev[0]),
    .sleep_exit(ev[1]), .flash_access(ev[2]), .rd_req(ev[3]), .rd_hit(hit), .rd_ack(rd_ack),
    .rd_busy(rd_busy));
  flash_array_model u_flash_array_model (.clk(clk), .reset(reset), .op_start(op_start),
    .op_done(op_done), .op_error(op_error));
  always @(posedge clk) begin
    if (op_start === 1'b1) begin
      {seen_cmd, seen_addr, seen_data} <= {op_cmd, op_addr, op_data};
      starts <= starts + 1;
    end
    if (buf_clear === 1'b1) clears <= clears + 1;
    if (cache_invalidate === 1'b1) invals <= invals + 1;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 r = reg_rdata;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    #1;
  endtask
  // Waits for ready, then issues a keyed command
  task automatic cmd(input logic [6:0] c);
    int k = 0;
    do begin rd(8'h14); k++; end while (r[0] !== 1'b1 && k < 50);
    check("ready", r[0], 1'b1);
    wr(8'h00, {16'h0, `EXECUTION_KEY, 1'b0, c});
    repeat (2) @(posedge clk);
  endtask
  function automatic int lat(input int p, input int ws, input int h);
    int m = (p == 0) ? (h ? 0 : ws) : (p == 1) ? (h ? 0 : ws + 1) : ws;
    return (m > 0) ? m + 1 : 1;
  endfunction
  task automatic stop_test;
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    stop_test;
  end
  initial begin
    d = $urandom(77);
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(8'h04); check("control_second", r, `CTRL_SECOND_RESET);
    rd(8'h08); check("memory_parameters", r, 32'h00030400);
    wr(8'h08, $urandom); rd(8'h08); check("memory_parameters", r, 32'h00030400);
    repeat (4) begin
      d = $urandom;
      wr(8'h04, d); rd(8'h04); check("control_second", r, d & `CTRL_SECOND_MASK);
      check("cache_enable", cache_enable, !d[18]);
    end
    foreach (codes[i]) begin
      d = {10'h0, 22'($urandom)};
      wr(8'h1c, d);
      cmd(codes[i]);
      check("op_cmd", seen_cmd, codes[i]);
      check("op_addr", seen_addr, codes[i] == 7'h45 ? 22'h003000 : d[21:0]);
    end
    check("op_data", seen_data, 8'h00);
    cmd(7'h42); rd(8'h18); check("power flag", r[0], 1'b1);
    cmd(7'h43); rd(8'h18); check("power flag", r[0], 1'b0);
    cmd(7'h44); cmd(7'h46);
    check("buffer clears", clears, 1);
    check("cache invalidates", invals, 1);
    n = starts;
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 32'h40 : (i == 1) ? 32'h07 + $urandom_range(56) : 32'h47 + $urandom_range(56);
      wr(8'h00, {16'h0, (i == 0) ? 8'h5a : 8'ha5, d[7:0]});
      rd(8'h18); check("programming error", r[2], 1'b1);
      wr(8'h18, 32'h4);
    end
    check("refused starts", starts - n, 0);
    n = starts;
    wr(8'h00, {16'h0, `EXECUTION_KEY, 8'h40});
    wr(8'h00, {16'h0, `EXECUTION_KEY, 8'h41});
    rd(8'h18); check("busy refusal", r[2], 1'b1);
    wr(8'h18, 32'h4);
    check("busy starts", starts - n, 1);
    @(posedge clk) security_active <= 1'b1;
    wr(8'h1c, 32'h002000); cmd(7'h06);
    rd(8'h18); check("aux refused", r[2], 1'b1);
    wr(8'h18, 32'h4);
    @(posedge clk) security_active <= 1'b0;
    cmd(7'h06); check("op_cmd", seen_cmd, 7'h06);
    cmd(7'h43);
    for (int m = 0; m < 2; m++) begin
      wr(8'h04, m ? 32'h80 : 32'h0);
      n = starts;
      @(posedge clk);
      buf_addr <= 22'($urandom);
      ev[5:4] <= 2'h3;
      @(posedge clk);
      ev[5:4] <= 2'h0;
      repeat (2) @(posedge clk);
      check("auto starts", starts - n, m == 0);
      if (m == 0) check("auto addr", {seen_cmd, seen_addr}, {7'h04, buf_addr});
      cmd(7'h43);
    end
    for (int p = 0; p < 4; p++)
      for (int h = 0; h < 2; h++) begin
        w = (p == 1 - h || p == 2 + h) ? 15 : $urandom_range(15);
        wr(8'h04, {14'h0, 2'(p), 11'h0, 4'(w), 1'b0});
        @(posedge clk);
        ev[3] <= 1'b1;
        hit <= h[0];
        @(posedge clk);
        ev[3] <= 1'b0;
        #1 n = 1;
        check("read busy", rd_busy, lat(p, w, h) > 1);
        while (rd_ack !== 1'b1 && n < 40) begin @(posedge clk); #1 n++; end
        check("read cycles", n, lat(p, w, h));
      end
    foreach (sp[i]) begin
      wr(8'h04, {22'h0, sp[i], 8'h80});
      pulse(0); check("sleep entry", power_reduced, sp[i] != 2'h3);
      pulse(1); check("sleep exit", power_reduced, sp[i] == 2'h0);
      pulse(2); check("first access", power_reduced, 1'b0);
    end
    @(posedge clk) ce <= 1'b0;
    wr(8'h04, 32'h0);
    ce <= 1'b1;
    rd(8'h04); check("frozen write", r, {22'h0, sp[2], 8'h80});
    stop_test;
  end
endmodule
`default_nettype wire
